/* hdl/sdcpi_dq_out.sv */
`timescale 1ns/1ps
module sdcpi_dq_out #(
    parameter int LANES = 2,
    parameter int CAS_LAT = 2
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic adv_i,
    input wire logic rd_valid_i,
    input wire logic [LANES*sdcpi_pkg::LANE_BITS-1:0] rd_data_i,
    input wire logic [LANES-1:0] mask_i,
    output logic [LANES*sdcpi_pkg::LANE_BITS-1:0] data_bus_o,
    output logic [LANES-1:0] data_bus_oe_o
);
    import sdcpi_pkg::*;

    localparam int W = LANES * LANE_BITS;
    localparam int DEPTH = CAS_LAT - 1;

    initial begin
        if (CAS_LAT < 2 || CAS_LAT > 3) begin
            $error("CAS_LAT must be 2 or 3");
        end
    end

    logic [W-1:0] data_pipe_reg [DEPTH];
    logic [DEPTH-1:0] valid_pipe_reg;
    logic [LANES-1:0] mask_reg;

    // ------------------------------------------------------------
    // latency pipe, frozen while the clock is suspended
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            valid_pipe_reg <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                data_pipe_reg[i] <= '0;
            end
        end else if (adv_i) begin
            valid_pipe_reg[0] <= rd_valid_i;
            data_pipe_reg[0] <= rd_data_i;
            for (int i = 1; i < DEPTH; i++) begin
                valid_pipe_reg[i] <= valid_pipe_reg[i-1];
                data_pipe_reg[i] <= data_pipe_reg[i-1];
            end
        end
    end

    // ------------------------------------------------------------
    // output registers and per-lane drivers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            mask_reg <= '0;
            data_bus_o <= '0;
        end else if (adv_i) begin
            mask_reg <= mask_i;
            data_bus_o <= data_pipe_reg[DEPTH-1];
        end
    end

    for (genvar g = 0; g < LANES; g++) begin : g_lane
        always_ff @(posedge clk_i) begin
            if (!reset_n_i) begin
                data_bus_oe_o[g] <= 1'b0;
            end else if (adv_i) begin
                data_bus_oe_o[g] <= valid_pipe_reg[DEPTH-1] & ~mask_reg[g];
            end
        end
    end

endmodule

/* hdl/sdcpi_top.sv */
`timescale 1ns/1ps
module sdcpi_top #(
    parameter int BURST_LEN = 4,
    parameter int CAS_LAT = 2,
    parameter int ROW_USED = 2,
    parameter int COL_BITS = 9
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire sdcpi_pkg::sdcpi_ctl_t ctl_i,
    input wire logic [sdcpi_pkg::BANK_BITS-1:0] bank_select_i,
    input wire logic [sdcpi_pkg::ADDR_BITS-1:0] addr_i,
    input wire logic low_byte_mask_i,
    input wire logic high_byte_mask_i,
    input wire logic [15:0] data_bus_i,
    output logic [15:0] data_bus_o,
    output logic [1:0] data_bus_oe_o,
    output logic input_buffer_en_o,
    output sdcpi_pkg::sdcpi_pwr_t power_state_o
);
    import sdcpi_pkg::*;

    localparam int LANES = 2;
    localparam int BL_BITS = $clog2(BURST_LEN);
    localparam int WORD_BITS = BANK_BITS + ROW_USED + COL_BITS;
    localparam int WORDS = 1 << WORD_BITS;

    initial begin
        if (BURST_LEN < 2 || BURST_LEN > 8 || (BURST_LEN & (BURST_LEN - 1)) != 0) begin
            $error("BURST_LEN must be 2, 4 or 8");
        end
        if (ROW_USED < 1 || ROW_USED > ADDR_BITS || COL_BITS <= BL_BITS || COL_BITS > 9) begin
            $error("array geometry out of range");
        end
    end

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    sdcpi_pwr_t pwr_reg;
    sdcpi_pwr_t pwr_next;
    logic core_en;
    logic [3:0] cmd_code;
    logic [LANES-1:0] mask;
    logic any_row_open;
    logic burst_busy;

    assign core_en = (pwr_reg == PWR_RUN);
    assign cmd_code = {ctl_i.cs_n, ctl_i.ras_n, ctl_i.cas_n, ctl_i.we_n};
    assign mask = {high_byte_mask_i, low_byte_mask_i};
    assign input_buffer_en_o = (pwr_reg == PWR_RUN) || (pwr_reg == PWR_SUSPEND);
    assign power_state_o = pwr_reg;

    logic is_act;
    logic is_rd;
    logic is_wr;
    logic is_pre;
    logic is_stop;
    logic is_self_ref;

    always_comb begin
        is_act = 1'b0;
        is_rd = 1'b0;
        is_wr = 1'b0;
        is_pre = 1'b0;
        is_stop = 1'b0;
        is_self_ref = 1'b0;
        if (core_en) begin
            unique case (cmd_code)
                CMD_ACTIVE: is_act = 1'b1;
                CMD_READ: is_rd = 1'b1;
                CMD_WRITE: is_wr = 1'b1;
                CMD_PRECHARGE: is_pre = 1'b1;
                CMD_BURST_STOP: is_stop = 1'b1;
                CMD_REFRESH: is_self_ref = ~ctl_i.cke;
                default: is_act = 1'b0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // bank rows
    // ------------------------------------------------------------
    logic [BANKS-1:0] row_open_reg;
    logic [ROW_USED-1:0] row_addr_reg [BANKS];

    for (genvar b = 0; b < BANKS; b++) begin : g_bank
        always_ff @(posedge clk_i) begin
            if (!reset_n_i) begin
                row_open_reg[b] <= 1'b0;
                row_addr_reg[b] <= '0;
            end else if (is_act && bank_select_i == BANK_BITS'(b)) begin
                row_open_reg[b] <= 1'b1;
                row_addr_reg[b] <= addr_i[ROW_USED-1:0];
            end else if (is_pre && (addr_i[ALL_BANKS_BIT] || bank_select_i == BANK_BITS'(b))) begin
                row_open_reg[b] <= 1'b0;
            end
        end
    end

    assign any_row_open = |row_open_reg;

    // ------------------------------------------------------------
    // burst counter
    // ------------------------------------------------------------
    logic [BL_BITS:0] burst_left_reg;
    logic burst_wr_reg;
    logic [BANK_BITS-1:0] burst_bank_reg;
    logic [COL_BITS-1:0] burst_col_reg;
    logic [COL_BITS-1:0] col_step;

    assign burst_busy = (burst_left_reg != '0);
    assign col_step = {burst_col_reg[COL_BITS-1:BL_BITS], burst_col_reg[BL_BITS-1:0] + 1'b1};

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            burst_left_reg <= '0;
            burst_wr_reg <= 1'b0;
            burst_bank_reg <= '0;
            burst_col_reg <= '0;
        end else if (core_en) begin
            if (is_rd || is_wr) begin
                burst_left_reg <= (BL_BITS + 1)'(BURST_LEN - 1);
                burst_wr_reg <= is_wr;
                burst_bank_reg <= bank_select_i;
                burst_col_reg <= col_step_start(addr_i[COL_BITS-1:0]);
            end else if (is_stop) begin
                burst_left_reg <= '0;
            end else if (burst_busy) begin
                burst_left_reg <= burst_left_reg - 1'b1;
                burst_col_reg <= col_step;
            end
        end
    end

    function automatic logic [COL_BITS-1:0] col_step_start(input logic [COL_BITS-1:0] c);
        col_step_start = {c[COL_BITS-1:BL_BITS], c[BL_BITS-1:0] + 1'b1};
    endfunction

    // ------------------------------------------------------------
    // array access
    // ------------------------------------------------------------
    logic acc_now;
    logic acc_wr;
    logic [BANK_BITS-1:0] acc_bank;
    logic [COL_BITS-1:0] acc_col;
    logic [WORD_BITS-1:0] acc_word;
    logic [15:0] rd_word;
    logic [LANE_BITS-1:0] mem [LANES][WORDS];

    assign acc_now = is_rd || is_wr || (core_en && burst_busy && !is_stop);
    assign acc_wr = (is_rd || is_wr) ? is_wr : burst_wr_reg;
    assign acc_bank = (is_rd || is_wr) ? bank_select_i : burst_bank_reg;
    assign acc_col = (is_rd || is_wr) ? addr_i[COL_BITS-1:0] : burst_col_reg;
    assign acc_word = {acc_bank, row_addr_reg[acc_bank], acc_col};

    for (genvar g = 0; g < LANES; g++) begin : g_mem
        always_ff @(posedge clk_i) begin
            if (acc_now && acc_wr && row_open_reg[acc_bank] && !mask[g]) begin
                mem[g][acc_word] <= data_bus_i[g*LANE_BITS +: LANE_BITS];
            end
        end
        assign rd_word[g*LANE_BITS +: LANE_BITS] = mem[g][acc_word];
    end

    sdcpi_dq_out #(
        .LANES(LANES),
        .CAS_LAT(CAS_LAT)
    ) u_dq_out (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .adv_i(core_en),
        .rd_valid_i(acc_now && !acc_wr && row_open_reg[acc_bank]),
        .rd_data_i(rd_word),
        .mask_i(mask),
        .data_bus_o(data_bus_o),
        .data_bus_oe_o(data_bus_oe_o)
    );

    // ------------------------------------------------------------
    // clock enable and power states
    // ------------------------------------------------------------
    always_comb begin
        pwr_next = pwr_reg;
        unique case (pwr_reg)
            PWR_RUN: begin
                if (!ctl_i.cke) begin
                    if (is_self_ref && !any_row_open) begin
                        pwr_next = PWR_SELF_REF;
                    end else if (burst_busy || is_rd || is_wr) begin
                        pwr_next = PWR_SUSPEND;
                    end else if (any_row_open || is_act) begin
                        pwr_next = PWR_ACT_PD;
                    end else begin
                        pwr_next = PWR_PRE_PD;
                    end
                end
            end
            PWR_SUSPEND: begin
                if (ctl_i.cke) begin
                    pwr_next = PWR_RUN;
                end
            end
            PWR_ACT_PD, PWR_PRE_PD, PWR_SELF_REF: begin
                if (ctl_i.cke) begin
                    pwr_next = PWR_RUN;
                end
            end
            default: pwr_next = PWR_RUN;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            pwr_reg <= PWR_RESET;
        end else begin
            pwr_reg <= pwr_next;
        end
    end

endmodule

/* pkg/sdcpi_pkg.sv */
package sdcpi_pkg;

    // ------------------------------------------------------------
    // pin groups
    // ------------------------------------------------------------
    typedef struct packed {
        logic cke;
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
    } sdcpi_ctl_t;

    // ------------------------------------------------------------
    // command codes {cs_n, ras_n, cas_n, we_n}
    // ------------------------------------------------------------
    localparam logic [3:0] CMD_LOAD_MODE = 4'h0;
    localparam logic [3:0] CMD_REFRESH = 4'h1;
    localparam logic [3:0] CMD_PRECHARGE = 4'h2;
    localparam logic [3:0] CMD_ACTIVE = 4'h3;
    localparam logic [3:0] CMD_WRITE = 4'h4;
    localparam logic [3:0] CMD_READ = 4'h5;
    localparam logic [3:0] CMD_BURST_STOP = 4'h6;
    localparam logic [3:0] CMD_NOP = 4'h7;

    // ------------------------------------------------------------
    // geometry and field positions
    // ------------------------------------------------------------
    localparam int BANKS = 4;
    localparam int BANK_BITS = 2;
    localparam int ADDR_BITS = 13;
    localparam int ALL_BANKS_BIT = 10;
    localparam int LANE_BITS = 8;

    // ------------------------------------------------------------
    // power / clock states, gray along run -> suspend -> power-down
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        PWR_RUN = 3'h0,
        PWR_SUSPEND = 3'h1,
        PWR_ACT_PD = 3'h3,
        PWR_PRE_PD = 3'h2,
        PWR_SELF_REF = 3'h6
    } sdcpi_pwr_t;

    localparam sdcpi_pwr_t PWR_RESET = PWR_RUN;

endpackage

/* sim/sdcpi_ctrl_model.sv */
`timescale 1ns/1ps
module sdcpi_ctrl_model (
    input wire logic clk_i,
    output sdcpi_pkg::sdcpi_ctl_t ctl_o,
    output logic [1:0] bank_o,
    output logic [12:0] addr_o,
    output logic [1:0] mask_o,
    output logic [15:0] data_o
);
    import sdcpi_pkg::*;

    initial begin
        ctl_o = {1'b1, 4'hf};
        bank_o = 2'h0;
        addr_o = 13'h0;
        mask_o = 2'h0;
        data_o = 16'h0;
    end

    // one command slot per clock, launched just after the edge
    task automatic step(input logic cke, input logic [3:0] code, input logic [1:0] bank,
                        input logic [12:0] addr, input logic [1:0] mask, input logic wr, input logic [15:0] data);
        @(posedge clk_i);
        #1;
        ctl_o = {cke, code};
        bank_o = bank;
        addr_o = addr;
        mask_o = mask;
        data_o = wr ? data : ~data_o;
    endtask
endmodule

/* sim/sdcpi_properties.sv */
`timescale 1ns/1ps
module sdcpi_checker
    import sdcpi_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire sdcpi_pkg::sdcpi_ctl_t ctl_i,
    input wire logic [sdcpi_pkg::BANK_BITS-1:0] bank_select_i,
    input wire logic [sdcpi_pkg::ADDR_BITS-1:0] addr_i,
    input wire logic low_byte_mask_i,
    input wire logic high_byte_mask_i,
    input wire logic [15:0] data_bus_i,
    input wire logic [15:0] data_bus_o,
    input wire logic [1:0] data_bus_oe_o,
    input wire logic input_buffer_en_o,
    input wire sdcpi_pkg::sdcpi_pwr_t power_state_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    logic run;
    logic [3:0] cmd;
    assign run = power_state_o == PWR_RUN;
    assign cmd = ctl_i[3:0];

    pd_buffers_off_a: assert property (power_state_o inside {PWR_ACT_PD, PWR_PRE_PD, PWR_SELF_REF}
        |-> !input_buffer_en_o) else $error("input buffers on in low power state");
    run_buffers_on_a: assert property ((run || power_state_o == PWR_SUSPEND) |-> input_buffer_en_o)
        else $error("input buffers off while clocked");
    cke_entry_a: assert property (run && !ctl_i.cke |=> !run)
        else $error("clock enable low did not stop the clock");
    cke_exit_a: assert property (!run && ctl_i.cke |=> run)
        else $error("clock enable high did not resume");
    frozen_out_a: assert property (!run && !ctl_i.cke
        |=> $stable(data_bus_o) && $stable(data_bus_oe_o) && $stable(power_state_o))
        else $error("outputs moved while clock stopped");
    rdwr_suspend_a: assert property (run && !ctl_i.cke && (cmd == CMD_READ || cmd == CMD_WRITE)
        |=> power_state_o == PWR_SUSPEND) else $error("access with cke low not suspended");
    self_ref_a: assert property (run && !ctl_i.cke && cmd == CMD_REFRESH
        |=> !run && power_state_o != PWR_PRE_PD) else $error("self refresh entry missed");
    low_mask_oe_a: assert property ((run && ctl_i.cke && low_byte_mask_i) ##1 (run && ctl_i.cke)
        |=> !data_bus_oe_o[0]) else $error("low lane driven after mask");
    high_mask_oe_a: assert property ((run && ctl_i.cke && high_byte_mask_i) ##1 (run && ctl_i.cke)
        |=> !data_bus_oe_o[1]) else $error("high lane driven after mask");
    reset_quiet_a: assert property (disable iff (1'b0) !reset_n_i |=> data_bus_oe_o == 2'h0 && run)
        else $error("outputs active after reset");

    cover property (power_state_o == PWR_SELF_REF);
    cover property (power_state_o == PWR_SUSPEND);
    cover property (data_bus_oe_o == 2'h3);
endmodule

bind sdcpi_top sdcpi_checker chk (.clk_i(clk_i), .reset_n_i(reset_n_i), .ctl_i(ctl_i),
    .bank_select_i(bank_select_i), .addr_i(addr_i), .low_byte_mask_i(low_byte_mask_i),
    .high_byte_mask_i(high_byte_mask_i), .data_bus_i(data_bus_i), .data_bus_o(data_bus_o),
    .data_bus_oe_o(data_bus_oe_o), .input_buffer_en_o(input_buffer_en_o), .power_state_o(power_state_o));

/* sim/sdcpi_tb_top.sv */
`timescale 1ns/1ps
module sdcpi_tb_top;
    import sdcpi_pkg::*;

    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    sdcpi_ctl_t ctl;
    logic [1:0] bank;
    logic [12:0] addr;
    logic [1:0] mask;
    logic [15:0] wdata;
    logic [15:0] data_bus_o;
    logic [1:0] data_bus_oe_o;
    logic input_buffer_en_o;
    sdcpi_pwr_t power_state_o;
    int n_mismatch = 0;
    int n_tests = 0;
    int cycles = 0;

    always #2.5 clk_i = ~clk_i;

    sdcpi_top uut (.clk_i(clk_i), .reset_n_i(reset_n_i), .ctl_i(ctl), .bank_select_i(bank), .addr_i(addr),
        .low_byte_mask_i(mask[0]), .high_byte_mask_i(mask[1]), .data_bus_i(wdata), .data_bus_o(data_bus_o),
        .data_bus_oe_o(data_bus_oe_o), .input_buffer_en_o(input_buffer_en_o), .power_state_o(power_state_o));
    sdcpi_ctrl_model ctrl (.clk_i(clk_i), .ctl_o(ctl), .bank_o(bank), .addr_o(addr), .mask_o(mask),
        .data_o(wdata));

    // ------------------------------------------------------------
    // compare and closing
    // ------------------------------------------------------------
    task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_pwr(input sdcpi_pwr_t got, input sdcpi_pwr_t exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            test_done();
        end
    end

    // ------------------------------------------------------------
    // helpers: burst of four beats plus drain, power step
    // ------------------------------------------------------------
    task automatic burst(input logic [3:0] code, input logic [1:0] bs, input logic [8:0] col, input logic hit,
                         input logic [63:0] wd, input logic [7:0] mk, input logic [63:0] rd);
        logic [1:0] oe_exp;
        logic [15:0] keep;
        for (int s = 0; s < 7; s++) begin
            ctrl.step(1'b1, (s == 0) ? code : 4'hf, bs, {4'h0, col}, (s < 4) ? mk[2*s +: 2] : 2'h0,
                      code == CMD_WRITE, (s < 4) ? wd[16*s +: 16] : 16'h0);
            oe_exp = (hit && s >= 2 && s < 6) ? ~mk[2*((s+2)%4) +: 2] : 2'h0;
            keep = {{8{oe_exp[1]}}, {8{oe_exp[0]}}};
            check_val({14'h0, data_bus_oe_o}, {14'h0, oe_exp});
            if (oe_exp != 2'h0) begin
                check_val(data_bus_o & keep, rd[16*((s+2)%4) +: 16] & keep);
            end
        end
    endtask

    task automatic pw(input logic cke, input logic [3:0] code, input logic [12:0] a, input sdcpi_pwr_t exp);
        ctrl.step(cke, code, 2'h1, a, 2'h0, 1'b0, 16'h0);
        ctrl.step(cke, 4'hf, 2'h1, a, 2'h0, 1'b0, 16'h0);
        check_pwr(power_state_o, exp);
        check_val({15'h0, input_buffer_en_o}, {15'h0, exp inside {PWR_RUN, PWR_SUSPEND}});
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        check_pwr(power_state_o, PWR_RUN);
        check_val({14'h0, data_bus_oe_o}, 16'h0);
        check_val({15'h0, input_buffer_en_o}, 16'h1);
        $display("test reset done");
    endtask

    task automatic t_mask_write();
        ctrl.step(1'b1, CMD_ACTIVE, 2'h1, 13'h1, 2'h0, 1'b0, 16'h0);
        burst(CMD_WRITE, 2'h1, 9'h4, 1'b0, 64'ha3a3_a2a2_a1a1_a0a0, 8'h00, 64'h0);
        burst(CMD_WRITE, 2'h1, 9'h4, 1'b0, 64'hb3b3_b2b2_b1b1_b0b0, 8'h24, 64'h0);
        burst(CMD_READ, 2'h1, 9'h4, 1'b1, 64'h0, 8'h00, 64'hb3b3_a2b2_b1a1_b0b0);
        burst(CMD_READ, 2'h1, 9'h6, 1'b1, 64'h0, 8'h81, 64'hb1a1_b0b0_b3b3_a2b2);
        $display("test mask write done");
    endtask

    task automatic t_suspend();
        logic [8:0] cke_seq;
        logic [63:0] rd;
        logic on;
        int beat;
        cke_seq = 9'h1f3;
        rd = 64'hb3b3_a2b2_b1a1_b0b0;
        for (int s = 0; s < 9; s++) begin
            ctrl.step(cke_seq[s], (s == 0) ? CMD_READ : 4'hf, 2'h1, 13'h4, 2'h0, 1'b0, 16'h0);
            on = (s >= 2 && s <= 7);
            beat = (s == 2) ? 0 : ((s <= 5) ? 1 : s - 4);
            check_val({14'h0, data_bus_oe_o}, on ? 16'h3 : 16'h0);
            if (on) begin
                check_val(data_bus_o, rd[16*beat +: 16]);
            end
            check_pwr(power_state_o, (s == 3 || s == 4) ? PWR_SUSPEND : PWR_RUN);
        end
        $display("test suspend done");
    endtask

    task automatic t_burst_stop();
        ctrl.step(1'b1, CMD_READ, 2'h1, 13'h4, 2'h0, 1'b0, 16'h0);
        ctrl.step(1'b1, CMD_BURST_STOP, 2'h1, 13'h0, 2'h0, 1'b0, 16'h0);
        check_val({14'h0, data_bus_oe_o}, 16'h0);
        ctrl.step(1'b1, 4'hf, 2'h1, 13'h0, 2'h0, 1'b0, 16'h0);
        check_val({14'h0, data_bus_oe_o}, 16'h3);
        check_val(data_bus_o, 16'hb0b0);
        ctrl.step(1'b1, 4'hf, 2'h1, 13'h0, 2'h0, 1'b0, 16'h0);
        check_val({14'h0, data_bus_oe_o}, 16'h0);
        $display("test burst stop done");
    endtask

    task automatic t_mid_reset();
        ctrl.step(1'b1, CMD_ACTIVE, 2'h1, 13'h1, 2'h0, 1'b0, 16'h0);
        ctrl.step(1'b1, CMD_READ, 2'h1, 13'h4, 2'h0, 1'b0, 16'h0);
        repeat (2) ctrl.step(1'b1, 4'hf, 2'h1, 13'h4, 2'h0, 1'b0, 16'h0);
        check_val({14'h0, data_bus_oe_o}, 16'h3);
        check_val(data_bus_o, 16'hb0b0);
        reset_n_i = 1'b0;
        repeat (2) @(posedge clk_i);
        #1;
        reset_n_i = 1'b1;
        check_pwr(power_state_o, PWR_RUN);
        check_val(data_bus_o, 16'h0);
        check_val({15'h0, input_buffer_en_o}, 16'h1);
        for (int s = 0; s < 4; s++) begin
            ctrl.step(1'b1, (s == 0) ? CMD_READ : 4'hf, 2'h1, 13'h4, 2'h0, 1'b0, 16'h0);
            check_val({14'h0, data_bus_oe_o}, 16'h0);
        end
        $display("test mid reset done");
    endtask

    task automatic t_cs_high();
        ctrl.step(1'b1, 4'hb, 2'h2, 13'h1, 2'h0, 1'b0, 16'h0);
        burst(CMD_READ, 2'h2, 9'h0, 1'b0, 64'h0, 8'h00, 64'h0);
        burst(4'hd, 2'h1, 9'h4, 1'b0, 64'h0, 8'h00, 64'h0);
        $display("test chip select done");
    endtask

    task automatic t_power();
        pw(1'b0, 4'hf, 13'h0, PWR_ACT_PD);
        pw(1'b1, 4'hf, 13'h0, PWR_RUN);
        pw(1'b1, CMD_PRECHARGE, 13'h400, PWR_RUN);
        pw(1'b0, 4'hf, 13'h0, PWR_PRE_PD);
        pw(1'b1, 4'hf, 13'h0, PWR_RUN);
        pw(1'b0, CMD_REFRESH, 13'h0, PWR_SELF_REF);
        pw(1'b1, 4'hf, 13'h0, PWR_RUN);
        pw(1'b1, CMD_ACTIVE, 13'h0, PWR_RUN);
        pw(1'b0, CMD_READ, 13'h0, PWR_SUSPEND);
        pw(1'b1, 4'hf, 13'h0, PWR_RUN);
        repeat (8) ctrl.step(1'b1, 4'hf, 2'h1, 13'h0, 2'h0, 1'b0, 16'h0);
        $display("test power done");
    endtask

    initial begin
        repeat (6) @(posedge clk_i);
        #1;
        reset_n_i = 1'b1;
        t_reset();
        t_mask_write();
        t_suspend();
        t_burst_stop();
        t_cs_high();
        t_power();
        t_mid_reset();
        test_done();
    end
endmodule
